// ===== shared/dsp_params.svh
// Register indices, field positions, reset values and divider counts
// for the serial port control block. Definitions only.
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define DSP_IDX_PWR 10'h087
`define DSP_IDX_SP1 10'h0c0
`define DSP_IDX_T2 10'h0c8
`define DSP_IDX_WD 10'h0d8
`define DSP_IDX_TXD 10'h0c1
`define DSP_IDX_RXD 10'h0c2

// Field positions.
`define DSP_PWR_DBL0 7
`define DSP_PWR_FES 6
`define DSP_WD_DBL1 7
`define DSP_T2_OVF 7
`define DSP_T2_RXSEL 5
`define DSP_T2_TXSEL 4
`define DSP_SP_M0 7
`define DSP_SP_M1 6
`define DSP_SP_MP 5
`define DSP_SP_REN 4
`define DSP_SP_TB8 3
`define DSP_SP_RB8 2
`define DSP_SP_TF 1
`define DSP_SP_RF 0

// Reset value of every control register.
`define DSP_RST_REG 8'h00

// Oscillator clocks per half shift clock in mode 0 (divide by 12 or 4).
`define DSP_M0_HALF_SLOW 5'h06
`define DSP_M0_HALF_FAST 5'h02
// Oscillator clocks per sample in mode 2 (bit = 16 samples: 64 or 32).
`define DSP_M2_SMP_SLOW 5'h04
`define DSP_M2_SMP_FAST 5'h02
// Timer overflows per sample in modes 1 and 3 (32 or 16 per bit).
`define DSP_TM_SMP_SLOW 5'h02
`define DSP_TM_SMP_FAST 5'h01
// Samples per bit and the three voting samples.
`define DSP_SMP_LAST 4'hf
`define DSP_SMP_V0 4'h7
`define DSP_SMP_V1 4'h8
`define DSP_SMP_V2 4'h9

// Bus responses.
`define DSP_RESP_OKAY 2'h0
`define DSP_RESP_SLVERR 2'h2

`endif

// ===== shared/dsp_pkg.sv
// Types shared by the serial port control block.
// Assumes nothing beyond a SystemVerilog compiler.
package dsp_pkg;

	// Operating mode as selected by the two mode bits.
	typedef enum logic [1:0] {MODE_SYNC8, MODE_ASYNC10, MODE_ASYNC11_FIX,
		MODE_ASYNC11_TMR} mode_t;

	// Asynchronous receiver states.
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// ===== rtl/dsp_sync2.sv
// Two-flop synchroniser for pin levels, one stage pair per bit.
// Assumes the inputs are asynchronous levels, not pulses.
`timescale 1ns/1ns
module dsp_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Levels.
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	initial
	begin
		if (WIDTH < 1) $error("dsp_sync2: WIDTH must be at least one.");
	end

	// The first stage feeds only the second stage.
	for (genvar g = 0; g < WIDTH; g++)
	begin : g_bit
		logic meta_q;
		always_ff @(posedge core_clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				meta_q <= 1'b1;
				sync_o[g] <= 1'b1;
			end
			else
			begin
				meta_q <= async_i[g];
				sync_o[g] <= meta_q;
			end
		end
	end

endmodule // dsp_sync2

// ===== rtl/dsp_baud_div.sv
// Divides a stream of source pulses into a registered tick pulse.
// Assumes pulse_i is high for single cycles and div_i is at least one.
`timescale 1ns/1ns
module dsp_baud_div #(
	parameter int WIDTH = 5
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Source and ratio.
	input wire logic pulse_i,
	input wire logic [WIDTH-1:0] div_i,
	// Divided tick.
	output logic tick_o
);

	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic tick_d;

	initial
	begin
		if (WIDTH < 1) $error("dsp_baud_div: WIDTH must be at least one.");
	end

	// One source pulse advances the count once; a ratio change mid-count
	// is caught by the greater-or-equal compare instead of wrapping.
	always_comb
	begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (pulse_i)
		begin
			if (cnt_q + 1'b1 >= div_i)
			begin
				cnt_d = '0;
				tick_d = 1'b1;
			end
			else
				cnt_d = cnt_q + 1'b1;
		end
	end

	// Registers only.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_o <= tick_d;
		end
	end

endmodule // dsp_baud_div

// ===== rtl/dsp_serial_ctrl.sv
// Serial port one engine with its control registers, the rate doubler
// and framing select bits, port zero baud ticks and timer 2 gating.
// Operation
// (RULE1) Port one timer modes use timer 1 only.
// (RULE2) Select set: bit 7 is framing flag.
// (RULE3) Two mode bits select modes 0 to 3.
// (RULE4) Multiproc modes 2/3: ninth bit 0 drops.
// (RULE5) Multiproc mode 1: bad stop drops.
// (RULE6) Mode 0 clock: osc/12, or osc/4.
// (RULE7) Receiver runs only while receive enabled.
// (RULE8) Modes 2/3 send tx_ninth_bit as ninth.
// (RULE9) rx_ninth_bit holds ninth or stop bit.
// (RULE10) Transmit flag set at last data bit.
// (RULE11) Receive flag set at frame end.
// (RULE12) Control register resets zero, fully read/write.
// (RULE13) Doubler bits double each port's rate.
// (RULE14) Doubler bits clear at reset.
// (RULE15) Port zero picks timer per direction.
// (RULE16) Mode 2 bit is osc/64 or /32.
// (RULE17) Timer rollovers divided by sixteen per bit.
// (RULE18) Timer 1 rate follows reload byte externally.
// (RULE19) Clock select makes timer 2 count half rate.
// (RULE20) Clock select blocks timer 2 flag, reload.
// (RULE21) Writing transmit data starts a transmission.
// (RULE22) Mode 0 receive starts when flag cleared.
// (RULE23) Each overflow pulse advances dividers once.
// Assumes an AXI4-Lite master on core_clk_i and single-cycle pulses on the
// timer overflow inputs; the timers themselves live outside this block.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dsp_params.svh"
module dsp_serial_ctrl #(
	parameter int AW = 12
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// AXI4-Lite write channels.
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// AXI4-Lite read channels.
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [AW-1:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	// Timer and power inputs from the same clock domain.
	input wire logic timer1_ovf_i,
	input wire logic timer2_ovf_i,
	input wire logic timer2_ext_reload_pin_i,
	input wire logic power_managed_mode_i,
	// Timer 2 control outputs.
	output logic timer2_half_rate_o,
	output logic timer2_reload_o,
	output logic timer2_irq_o,
	// Port zero baud sample ticks, sixteen per bit.
	output logic p0_tx_tick_o,
	output logic p0_rx_tick_o,
	// Port one pins; the receive pin is two-way in mode 0.
	output logic port1_tx_pin_o,
	input wire logic port1_rx_pin_i,
	output logic port1_rx_pin_o,
	output logic port1_rx_pin_oe_o
);

	initial
	begin
		if (AW < 12) $error("dsp_serial_ctrl: AW must be at least 12.");
	end

	// Register state.
	logic dbl0_q, dbl0_d, dbl1_q, dbl1_d, fes_q, fes_d;
	logic t2ovf_q, t2ovf_d, rxsel_q, rxsel_d, txsel_q, txsel_d;
	logic sm0_q, sm0_d, fe_q, fe_d, sm1_q, sm1_d, mp_q, mp_d, ren_q, ren_d;
	logic tb8_q, tb8_d, rb8_q, rb8_d, tf_q, tf_d, rf_q, rf_d;
	logic [7:0] rxbuf_q, rxbuf_d;
	// Bus state.
	logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
	logic rvalid_q, rvalid_d;
	logic [9:0] waddr_q, waddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wlane_q, wlane_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	// Engine state.
	logic busy_q, busy_d, sdir_rx_q, sdir_rx_d;
	logic [10:0] sh_q, sh_d;
	logic [3:0] bits_q, bits_d, smp_q, smp_d;
	dsp_pkg::rx_state_t rx_state_q, rx_state_d;
	logic [3:0] rsmp_q, rsmp_d, rcnt_q, rcnt_d;
	logic [8:0] rsh_q, rsh_d;
	logic [1:0] vote_q, vote_d;
	logic rx_prev_q, rx_prev_d;
	logic txo_q, txo_d, rxo_q, rxo_d, rxoe_q, rxoe_d;
	// Combinational helpers.
	dsp_pkg::mode_t mode;
	logic rx_s, smp_tick, p1_src, t2_sel, do_write, tx_start, m0_rx_start;
	logic tf_set, rf_set, fe_set, rx_bit, rb8_val, is11;
	logic [4:0] p1_div, p0_div;
	logic [7:0] rx_data;
	logic [9:0] raddr;

	// The receive pin is a level from outside, so it is synchronised.
	dsp_sync2 #(.WIDTH(1)) u_rx_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(port1_rx_pin_i),
		.sync_o(rx_s)
	);

	// Mode decode and port one baud source selection.
	always_comb
	begin
		mode = dsp_pkg::mode_t'({sm0_q, sm1_q}); // RULE3
		is11 = sm0_q;
		t2_sel = rxsel_q | txsel_q;
		case (mode)
			dsp_pkg::MODE_SYNC8:
			begin
				p1_src = 1'b1;
				p1_div = (mp_q && !power_managed_mode_i) ?
					`DSP_M0_HALF_FAST : `DSP_M0_HALF_SLOW; // RULE6
			end
			dsp_pkg::MODE_ASYNC11_FIX:
			begin
				p1_src = 1'b1;
				p1_div = dbl1_q ? `DSP_M2_SMP_FAST : `DSP_M2_SMP_SLOW; // RULE16
			end
			default:
			begin
				p1_src = timer1_ovf_i; // RULE1 RULE18
				p1_div = dbl1_q ? `DSP_TM_SMP_FAST : `DSP_TM_SMP_SLOW; // RULE13
			end
		endcase
		p0_div = dbl0_q ? `DSP_TM_SMP_FAST : `DSP_TM_SMP_SLOW; // RULE13
	end

	// Each divider sees every overflow pulse once; sharing is safe. RULE23
	dsp_baud_div #(.WIDTH(5)) u_p1_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pulse_i(p1_src),
		.div_i(p1_div),
		.tick_o(smp_tick)
	);
	dsp_baud_div #(.WIDTH(5)) u_p0_tx_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pulse_i(txsel_q ? timer2_ovf_i : timer1_ovf_i), // RULE15
		.div_i(txsel_q ? `DSP_TM_SMP_FAST : p0_div),
		.tick_o(p0_tx_tick_o)
	);
	dsp_baud_div #(.WIDTH(5)) u_p0_rx_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pulse_i(rxsel_q ? timer2_ovf_i : timer1_ovf_i), // RULE15
		.div_i(rxsel_q ? `DSP_TM_SMP_FAST : p0_div),
		.tick_o(p0_rx_tick_o)
	);

	// Timer 2 in baud service counts at half rate with flag, interrupt
	// and external reload suppressed.
	assign timer2_half_rate_o = t2_sel; // RULE19
	assign timer2_reload_o = timer2_ext_reload_pin_i & ~t2_sel; // RULE20
	assign timer2_irq_o = t2ovf_q & ~t2_sel; // RULE20

	// Bus slave: address and data are taken in either order and the write
	// lands once both are held; a read answers on the next edge.
	always_comb
	begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		waddr_d = waddr_q;
		wbyte_d = wbyte_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		raddr = s_axi_araddr_i[11:2];
		do_write = aw_held_q && w_held_q && !bvalid_q;
		if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			aw_held_d = 1'b1;
			waddr_d = s_axi_awaddr_i[11:2];
		end
		if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			w_held_d = 1'b1;
			wbyte_d = s_axi_wdata_i[7:0];
			wlane_d = s_axi_wstrb_i[0];
		end
		if (do_write)
		begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `DSP_RESP_OKAY;
			case (waddr_q)
				`DSP_IDX_PWR, `DSP_IDX_SP1, `DSP_IDX_T2, `DSP_IDX_WD,
				`DSP_IDX_TXD, `DSP_IDX_RXD: bresp_d = `DSP_RESP_OKAY;
				default: bresp_d = `DSP_RESP_SLVERR;
			endcase
		end
		else if (bvalid_q && s_axi_bready_i)
			bvalid_d = 1'b0;
		if (s_axi_arvalid_i && !rvalid_q)
		begin
			rvalid_d = 1'b1;
			rresp_d = `DSP_RESP_OKAY;
			rdata_d = 32'h0000_0000;
			case (raddr)
				`DSP_IDX_PWR: rdata_d[7:6] = {dbl0_q, fes_q};
				`DSP_IDX_SP1: rdata_d[7:0] = {fes_q ? fe_q : sm0_q, sm1_q, mp_q,
					ren_q, tb8_q, rb8_q, tf_q, rf_q}; // RULE2 RULE12
				`DSP_IDX_T2: rdata_d[7:0] = {t2ovf_q, 1'b0, rxsel_q, txsel_q,
					4'h0};
				`DSP_IDX_WD: rdata_d[7] = dbl1_q;
				`DSP_IDX_RXD: rdata_d[7:0] = rxbuf_q;
				`DSP_IDX_TXD: rdata_d[7:0] = 8'h00;
				default: rresp_d = `DSP_RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && s_axi_rready_i)
			rvalid_d = 1'b0;
	end

	assign s_axi_awready_o = !aw_held_q && !bvalid_q;
	assign s_axi_wready_o = !w_held_q && !bvalid_q;
	assign s_axi_arready_o = !rvalid_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	// Register file; hardware sets of the flags win over software clears.
	always_comb
	begin
		{dbl0_d, fes_d, dbl1_d, rxsel_d, txsel_d} =
			{dbl0_q, fes_q, dbl1_q, rxsel_q, txsel_q};
		{sm0_d, fe_d, sm1_d, mp_d, ren_d, tb8_d, rb8_d, tf_d, rf_d} =
			{sm0_q, fe_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, tf_q, rf_q};
		t2ovf_d = t2ovf_q;
		rxbuf_d = rxbuf_q;
		tx_start = 1'b0;
		if (do_write && wlane_q)
		begin
			case (waddr_q)
				`DSP_IDX_PWR:
				begin
					dbl0_d = wbyte_q[`DSP_PWR_DBL0];
					fes_d = wbyte_q[`DSP_PWR_FES];
				end
				`DSP_IDX_WD: dbl1_d = wbyte_q[`DSP_WD_DBL1];
				`DSP_IDX_T2:
				begin
					t2ovf_d = wbyte_q[`DSP_T2_OVF];
					rxsel_d = wbyte_q[`DSP_T2_RXSEL];
					txsel_d = wbyte_q[`DSP_T2_TXSEL];
				end
				`DSP_IDX_SP1:
				begin
					if (fes_q)
						fe_d = wbyte_q[`DSP_SP_M0]; // RULE2
					else
						sm0_d = wbyte_q[`DSP_SP_M0];
					sm1_d = wbyte_q[`DSP_SP_M1]; // RULE12
					mp_d = wbyte_q[`DSP_SP_MP];
					ren_d = wbyte_q[`DSP_SP_REN];
					tb8_d = wbyte_q[`DSP_SP_TB8];
					rb8_d = wbyte_q[`DSP_SP_RB8];
					tf_d = wbyte_q[`DSP_SP_TF];
					rf_d = wbyte_q[`DSP_SP_RF];
				end
				`DSP_IDX_TXD: tx_start = !busy_q; // RULE21
				default: tx_start = 1'b0;
			endcase
		end
		if (timer2_ovf_i && !t2_sel)
			t2ovf_d = 1'b1; // RULE20
		if (fe_set)
			fe_d = 1'b1; // RULE2
		if (tf_set)
			tf_d = 1'b1; // RULE10
		if (rf_set)
		begin
			rf_d = 1'b1; // RULE11
			rb8_d = (mode == dsp_pkg::MODE_SYNC8) ? rb8_q : rb8_val; // RULE9
			rxbuf_d = rx_data;
		end
	end

	// Transmit and mode 0 shifter, then the asynchronous receiver.
	always_comb
	begin
		{busy_d, sdir_rx_d, sh_d, bits_d, smp_d} =
			{busy_q, sdir_rx_q, sh_q, bits_q, smp_q};
		rx_state_d = rx_state_q;
		{rsmp_d, rcnt_d, rsh_d, vote_d} = {rsmp_q, rcnt_q, rsh_q, vote_q};
		rx_prev_d = rx_s;
		tf_set = 1'b0;
		rf_set = 1'b0;
		fe_set = 1'b0;
		rx_bit = (vote_q[1] & vote_q[0]) | (vote_q[1] & rx_s) |
			(vote_q[0] & rx_s);
		rb8_val = (mode == dsp_pkg::MODE_ASYNC10) ? rx_bit : rsh_q[8];
		rx_data = (mode == dsp_pkg::MODE_SYNC8) ? sh_q[7:0] :
			(is11 ? rsh_q[7:0] : rsh_q[8:1]);
		m0_rx_start = (mode == dsp_pkg::MODE_SYNC8) && ren_q && !rf_q &&
			!busy_q && !tx_start; // RULE22 RULE7
		if (tx_start)
		begin
			busy_d = 1'b1;
			sdir_rx_d = 1'b0;
			smp_d = 4'h0;
			if (mode == dsp_pkg::MODE_SYNC8)
			begin
				sh_d = {3'h7, wbyte_q};
				bits_d = 4'h8;
			end
			else
			begin
				sh_d = {1'b1, is11 ? tb8_q : 1'b1, wbyte_q, 1'b0}; // RULE8
				bits_d = is11 ? 4'hb : 4'ha;
			end
		end
		else if (m0_rx_start)
		begin
			busy_d = 1'b1;
			sdir_rx_d = 1'b1;
			smp_d = 4'h0;
			bits_d = 4'h8;
		end
		else if (busy_q && smp_tick && mode == dsp_pkg::MODE_SYNC8)
		begin
			// Bit 0 of the count is the shift clock phase: low, then high.
			smp_d = {3'h0, ~smp_q[0]};
			if (!smp_q[0] && sdir_rx_q)
				sh_d = {3'h7, rx_s, sh_q[7:1]};
			if (smp_q[0])
			begin
				if (!sdir_rx_q)
					sh_d = {1'b1, sh_q[10:1]};
				bits_d = bits_q - 4'h1;
				if (bits_q == 4'h1)
				begin
					busy_d = 1'b0;
					tf_set = !sdir_rx_q; // RULE10
					rf_set = sdir_rx_q; // RULE11
				end
			end
		end
		else if (busy_q && smp_tick)
		begin
			smp_d = smp_q + 4'h1; // RULE17
			if (smp_q == `DSP_SMP_LAST)
			begin
				sh_d = {1'b1, sh_q[10:1]};
				bits_d = bits_q - 4'h1;
				tf_set = (bits_q == 4'h2); // RULE10
				busy_d = (bits_q != 4'h1);
			end
		end
		// Asynchronous receiver, sampled three times around mid-bit.
		if (!ren_q || mode == dsp_pkg::MODE_SYNC8)
			rx_state_d = dsp_pkg::RX_IDLE; // RULE7
		else if (rx_state_q == dsp_pkg::RX_IDLE)
		begin
			if (rx_prev_q && !rx_s)
			begin
				rx_state_d = dsp_pkg::RX_START;
				rsmp_d = 4'h0;
			end
		end
		else if (smp_tick)
		begin
			rsmp_d = rsmp_q + 4'h1;
			if (rsmp_q == `DSP_SMP_V0 || rsmp_q == `DSP_SMP_V1)
				vote_d = {vote_q[0], rx_s};
			if (rsmp_q == `DSP_SMP_V2)
			begin
				case (rx_state_q)
					dsp_pkg::RX_START:
					begin
						rx_state_d = rx_bit ? dsp_pkg::RX_IDLE : dsp_pkg::RX_DATA;
						rcnt_d = 4'h0;
					end
					dsp_pkg::RX_DATA:
					begin
						rsh_d = {rx_bit, rsh_q[8:1]};
						rcnt_d = rcnt_q + 4'h1;
						if (rcnt_q == (is11 ? 4'h8 : 4'h7))
							rx_state_d = dsp_pkg::RX_STOP;
					end
					default:
					begin
						rx_state_d = dsp_pkg::RX_IDLE;
						fe_set = fes_q && !rx_bit; // RULE2
						rf_set = !rf_q && (!mp_q || rb8_val); // RULE4 RULE5 RULE11
					end
				endcase
			end
		end
		// Pin drivers are registered to keep the pins glitch free.
		txo_d = 1'b1;
		rxo_d = 1'b1;
		rxoe_d = 1'b0;
		if (mode == dsp_pkg::MODE_SYNC8)
		begin
			txo_d = !busy_d || smp_d[0];
			rxo_d = sh_d[0];
			rxoe_d = busy_d && !sdir_rx_d;
		end
		else if (busy_d)
			txo_d = sh_d[0];
	end

	assign port1_tx_pin_o = txo_q;
	assign port1_rx_pin_o = rxo_q;
	assign port1_rx_pin_oe_o = rxoe_q;

	// All state registers; reset clears all but sh_q, rx_prev_q, txo_q and rxo_q, which load ones. RULE12 RULE14
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			{dbl0_q, fes_q, dbl1_q, t2ovf_q, rxsel_q, txsel_q} <= 6'h00;
			{sm0_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, tf_q, rf_q} <= `DSP_RST_REG;
			{fe_q, rxbuf_q} <= 9'h000;
			{aw_held_q, w_held_q, bvalid_q, rvalid_q, wlane_q} <= 5'h00;
			{waddr_q, wbyte_q, bresp_q, rresp_q} <= 22'h00_0000;
			rdata_q <= 32'h0000_0000;
			{busy_q, sdir_rx_q, sh_q, bits_q, smp_q} <= 21'h07_ff00;
			rx_state_q <= dsp_pkg::RX_IDLE;
			{rsmp_q, rcnt_q, rsh_q, vote_q} <= 19'h0_0000;
			{rx_prev_q, txo_q, rxo_q, rxoe_q} <= 4'he;
		end
		else
		begin
			{dbl0_q, fes_q, dbl1_q, t2ovf_q, rxsel_q, txsel_q} <=
				{dbl0_d, fes_d, dbl1_d, t2ovf_d, rxsel_d, txsel_d};
			{sm0_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, tf_q, rf_q} <=
				{sm0_d, sm1_d, mp_d, ren_d, tb8_d, rb8_d, tf_d, rf_d};
			{fe_q, rxbuf_q} <= {fe_d, rxbuf_d};
			{aw_held_q, w_held_q, bvalid_q, rvalid_q, wlane_q} <=
				{aw_held_d, w_held_d, bvalid_d, rvalid_d, wlane_d};
			{waddr_q, wbyte_q, bresp_q, rresp_q} <=
				{waddr_d, wbyte_d, bresp_d, rresp_d};
			rdata_q <= rdata_d;
			{busy_q, sdir_rx_q, sh_q, bits_q, smp_q} <=
				{busy_d, sdir_rx_d, sh_d, bits_d, smp_d};
			rx_state_q <= rx_state_d;
			{rsmp_q, rcnt_q, rsh_q, vote_q} <= {rsmp_d, rcnt_d, rsh_d, vote_d};
			{rx_prev_q, txo_q, rxo_q, rxoe_q} <= {rx_prev_d, txo_d, rxo_d, rxoe_d};
		end
	end

	// Checks on the engine and the control bits.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	p1_timer_src_a: assert property (smp_tick && $past(sm1_q) && sm1_q &&
		$past(mode) == mode |-> $past(timer1_ovf_i)) // RULE1
		else $error("Port one timer tick without a timer 1 overflow.");
	fe_cause_a: assert property ($rose(fe_q) |-> $past(fes_q))
		else $error("Framing flag rose with the select clear."); // RULE2
	mp_ninth_a: assert property (rf_set && is11 && mp_q && rx_state_q ==
		dsp_pkg::RX_STOP |-> rsh_q[8]) // RULE4
		else $error("Receive flag set on a zero ninth bit.");
	mp_stop_a: assert property (rf_set && mode == dsp_pkg::MODE_ASYNC10 &&
		mp_q |-> rx_bit) // RULE5
		else $error("Receive flag set on a bad stop bit.");
	m0_clock_a: assert property (mode == dsp_pkg::MODE_SYNC8 && busy_q &&
		!power_managed_mode_i && !mp_q && $rose(port1_tx_pin_o)
		|=> !$rose(port1_tx_pin_o)[*5]) // RULE6
		else $error("Mode 0 slow shift clock too fast.");
	ren_idle_a: assert property (!ren_q |=> rx_state_q ==
		dsp_pkg::RX_IDLE) // RULE7
		else $error("Receiver active while disabled.");
	ninth_tx_a: assert property (tx_start && is11 |=> sh_q[9] ==
		$past(tb8_q)) // RULE8
		else $error("Ninth transmit bit not loaded.");
	t2_gate_a: assert property (t2_sel |-> !timer2_reload_o &&
		!timer2_irq_o) // RULE20
		else $error("Timer 2 reload or interrupt while in baud service.");
	tf_sticky_a: assert property (tf_set |=> tf_q) // RULE10
		else $error("Transmit flag lost its set.");

	tx_done_c: cover property (tf_set && is11);
	rx_done_c: cover property (rf_set && mode == dsp_pkg::MODE_ASYNC10);
	m0_rx_c: cover property (rf_set && mode == dsp_pkg::MODE_SYNC8);

endmodule // dsp_serial_ctrl

// ===== verification/serial_peer.sv
// Far-side serial model that sends asynchronous frames into port one.
// Assumes the bench gives the bit period in core clock cycles.
`timescale 1ns/1ns
module serial_peer (
	// Clock.
	input wire logic core_clk_i,
	// Line toward the port receive pin.
	output logic line_o
);
	// The line idles at the stop level between frames.
	initial line_o = 1'b1;

	// Holds the line at a level, as a mode 0 data source would.
	task automatic hold(input logic v);
		line_o <= v;
	endtask

	// Start bit, nine bits LSb first, then the chosen stop level.
	task automatic send(input logic [8:0] v, input logic stop, input int per);
		int i;
		@(posedge core_clk_i);
		line_o <= 1'b0;
		repeat (per) @(posedge core_clk_i);
		for (i = 0; i < 9; i++)
		begin
			line_o <= v[i];
			repeat (per) @(posedge core_clk_i);
		end
		line_o <= stop;
		repeat (per) @(posedge core_clk_i);
		line_o <= 1'b1;
	endtask
endmodule // serial_peer

// ===== verification/testbench.sv
// Self-checking bench for the serial port control block over AXI4-Lite.
// Assumes the peer model drives the receive pin outside mode 0.
`timescale 1ns/1ns
module testbench;
	logic clk, rst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [11:0] awa, ara;
	logic [31:0] wd, rd, d;
	logic [1:0] bresp, rresp, r;
	logic t1, t2, ext, tx, rxo, rxoe, peer, half, rld, irq, ptx, prx, txp;
	logic [7:0] m0;
	int fails = 0, num_checks = 0, ntx = 0, nrx = 0, i;

	// Clock at 100 MHz.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// The port only sees the peer's line while the port is not driving.
	serial_peer PEER (.core_clk_i(clk), .line_o(peer));

	dsp_serial_ctrl DUT (.core_clk_i(clk), .rst_n_i(rst_n),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
		.s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .timer1_ovf_i(t1),
		.timer2_ovf_i(t2), .timer2_ext_reload_pin_i(ext),
		.power_managed_mode_i(1'b0), .timer2_half_rate_o(half),
		.timer2_reload_o(rld), .timer2_irq_o(irq), .p0_tx_tick_o(ptx),
		.p0_rx_tick_o(prx), .port1_tx_pin_o(tx),
		.port1_rx_pin_i(rxoe ? rxo : peer), .port1_rx_pin_o(rxo),
		.port1_rx_pin_oe_o(rxoe));

	// Tick counters; a registered pulse is counted once per high cycle.
	always @(posedge clk)
	begin
		if (ptx === 1'b1) ntx++;
		if (prx === 1'b1) nrx++;
		// Mode 0 data is taken at each rising shift clock while driven.
		if (tx === 1'b1 && txp === 1'b0 && rxoe === 1'b1)
			m0 <= {rxo, m0[7:1]};
		txp <= tx;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		chk({30'h0, g}, {30'h0, e});
	endtask

	// Readies are looked at on the falling edge, stable before the next rise.
	// The leading edge keeps back-to-back calls from driving twice at once.
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
		logic ta, tw, tb;
		@(posedge clk);
		awa <= a;
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = awv & awr;
			tw = wv & wr;
			tb = bv;
			r = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		while (tb !== 1'b1);
		br <= 1'b0;
	endtask

	task automatic rd_reg(input logic [11:0] a);
		logic ta, tr;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = arv & arr;
			tr = rv;
			d = rd;
			r = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end
		while (tr !== 1'b1);
		rr <= 1'b0;
	endtask

	// Single-cycle overflow pulses, spaced so none merge.
	task automatic pulse(input logic which, input int n);
		repeat (n)
		begin
			if (which) t2 <= 1'b1;
			else t1 <= 1'b1;
			@(posedge clk);
			t1 <= 1'b0;
			t2 <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Cuts a hang short well past the expected run of a few thousand cycles.
	initial
	begin
		#400000;
		fails++;
		results();
	end

	initial
	begin
		{rst_n, awv, wv, br, arv, rr, t1, t2, ext} = 9'h000;
		{awa, ara, wd} = 56'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_reg(12'h300); chk(d, 32'h0);
		rd_reg(12'h21c); chk(d, 32'h0);
		rd_reg(12'h360); chk(d, 32'h0);
		rd_reg(12'h100); chk_resp(r, 2'h2);
		wr_reg(12'h100, 8'h00); chk_resp(r, 2'h2);
		wr_reg(12'h300, 8'h7c); chk_resp(r, 2'h0);
		rd_reg(12'h300); chk(d, 32'h7c);
		$display("registers done");
		// Timer 1 slow: two overflows per sample on both directions.
		pulse(1'b0, 8); chk(nrx, 4); chk(ntx, 4);
		wr_reg(12'h21c, 8'h80); ntx = 0; nrx = 0;
		pulse(1'b0, 8); chk(nrx, 8); chk(ntx, 8);
		wr_reg(12'h320, 8'ha0); ntx = 0; nrx = 0; ext <= 1'b1;
		pulse(1'b1, 8); chk(nrx, 8); chk(ntx, 0);
		chk(half, 1); chk(rld, 0);
		chk(irq, 0);
		wr_reg(12'h320, 8'h00); chk(rld, 1); chk(half, 0);
		pulse(1'b1, 1); chk(irq, 1);
		ext <= 1'b0;
		$display("baud ticks done");
		// Mode 2 doubled: 32 clocks per bit, ninth bit from the control.
		wr_reg(12'h360, 8'h80);
		wr_reg(12'h300, 8'h80);
		wr_reg(12'h304, 8'ha5);
		i = 0;
		while (tx !== 1'b0 && i < 2000)
		begin
			@(negedge clk);
			i++;
		end
		repeat (16) @(negedge clk);
		for (i = 0; i < 11; i++)
		begin
			chk(tx, (i == 0 || i == 9) ? 0 :
				(i < 9) ? 8'ha5 >> (i - 1) & 1 : 1);
			repeat (32) @(negedge clk);
		end
		rd_reg(12'h300); chk(d, 32'h82);
		$display("transmit done");
		wr_reg(12'h300, 8'h90);
		PEER.send(9'h13c, 1'b1, 32);
		repeat (40) @(posedge clk);
		rd_reg(12'h300); chk(d, 32'h95);
		rd_reg(12'h308); chk(d, 32'h3c);
		wr_reg(12'h300, 8'hb0);
		PEER.send(9'h055, 1'b1, 32);
		repeat (40) @(posedge clk);
		rd_reg(12'h300); chk(d, 32'hb0);
		wr_reg(12'h21c, 8'h40);
		PEER.send(9'h111, 1'b0, 32);
		repeat (40) @(posedge clk);
		rd_reg(12'h300); chk(d & 32'h80, 32'h80);
		$display("receive done");
		// Mode 0: eight low bits in, then one byte out on the data pin.
		wr_reg(12'h21c, 8'h00);
		PEER.hold(1'b0);
		wr_reg(12'h300, 8'h10);
		repeat (120) @(posedge clk);
		rd_reg(12'h300); chk(d, 32'h11);
		rd_reg(12'h308); chk(d, 32'h0);
		wr_reg(12'h304, 8'h5a);
		repeat (120) @(posedge clk);
		chk(m0, 8'h5a);
		rd_reg(12'h300); chk(d, 32'h13);
		$display("mode 0 done");
		results();
	end
endmodule // testbench
